// [include/iwic_pkg.sv]
package iwic_pkg;
    // task-file offsets; reads of 1 and 7 return error and status
    localparam logic [3:0] TF_FEAT   = 4'h1;
    localparam logic [3:0] TF_SECCNT = 4'h2;
    localparam logic [3:0] TF_SECNUM = 4'h3;
    localparam logic [3:0] TF_CYLLO  = 4'h4;
    localparam logic [3:0] TF_CYLHI  = 4'h5;
    localparam logic [3:0] TF_DRVHD  = 4'h6;
    localparam logic [3:0] TF_CMD    = 4'h7;
    localparam logic [3:0] ID_SEL    = 4'h8;
    localparam logic [3:0] ID_LO     = 4'h9;
    localparam logic [3:0] ID_HI     = 4'ha;
    localparam logic [3:0] APM_REG   = 4'hb;

    localparam logic [7:0] OP_IDLE_A   = 8'h97;
    localparam logic [7:0] OP_IDLE_B   = 8'he3;
    localparam logic [7:0] OP_IMM_A    = 8'h95;
    localparam logic [7:0] OP_IMM_B    = 8'he1;
    localparam logic [7:0] OP_SEC_UNLK = 8'hf2;
    localparam logic [7:0] OP_SEC_ERAS = 8'hf4;

    localparam int ST_BSY  = 7;
    localparam int ST_RDY  = 6;
    localparam int ST_ERR  = 0;
    localparam int ER_ABRT = 2;
    localparam int DRV_BIT = 4;

    localparam logic [7:0] APM_RST   = 8'h80;
    localparam logic [2:0] SEC_TRIES = 3'h5;
    localparam int PD_TICK_MS = 5;
    localparam int CLK_KHZ    = 100000;

    // identify word selector values
    localparam logic [2:0] IDX_ERASE = 3'h0;
    localparam logic [2:0] IDX_ENH   = 3'h1;
    localparam logic [2:0] IDX_APM   = 3'h2;
    localparam logic [2:0] IDX_SEC   = 3'h3;
    localparam logic [2:0] IDX_PWR   = 3'h4;
    localparam logic [2:0] IDX_KEY   = 3'h5;
    localparam logic [2:0] IDX_ATA   = 3'h6;
    localparam logic [2:0] IDX_PCC   = 3'h7;

    localparam int SEC_LVL = 8;
    localparam int SEC_ENH = 5;
    localparam int SEC_EXP = 4;
    localparam int SEC_FRZ = 3;
    localparam int SEC_LCK = 2;
    localparam int SEC_EN  = 1;
    localparam int SEC_CAP = 0;
    localparam int PR_VLD  = 15;
    localparam int PR_RSV  = 14;
    localparam int PR_NOXP = 13;
    localparam int PR_XE   = 12;
    localparam int PR_CUR  = 11;
    localparam int KEY_MP  = 0;
    localparam int ATA_PMX = 0;
    localparam int ATA_MMX = 3;
    localparam int ATA_PSL = 6;
    localparam int ATA_MSL = 9;
    localparam int PCC_IO  = 0;
    localparam int PCC_MEM = 3;
    localparam logic [2:0] ADV_MAX = 3'h2;
    localparam logic [2:0] CYC_MAX = 3'h3;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wrData;
        logic       wrEn;
        logic       rdEn;
    } iwic_bus_t;

    typedef struct packed {
        logic [7:0]  eraseNorm;
        logic [7:0]  eraseEnh;
        logic        secSupported;
        logic        enhEraseSup;
        logic        secEnabled;
        logic        secMaxLevel;
        logic        secLocked;
        logic        secFrozen;
        logic        powerValid;
        logic        noLevel1Cmds;
        logic        level1Disabled;
        logic [11:0] maxCurrent;
        logic        mediaProt;
        logic [2:0]  pioMax;
        logic [2:0]  mwMax;
        logic [2:0]  pioSel;
        logic [2:0]  mwSel;
        logic        udmaSel;
        logic [2:0]  ioCycMax;
        logic [2:0]  memCycMax;
    } iwic_cfg_t;

    typedef enum logic [1:0] {PH_READY, PH_BUSY, PH_ENTER} iwic_phase_t;
    typedef enum logic [1:0] {ACT_IDLE, ACT_IMM, ACT_ABORT, ACT_FWD}
        iwic_act_t;

    typedef struct packed {
        iwic_phase_t phase;
        iwic_act_t   act;
        logic        busy;
        logic        err;
        logic        abrt;
        logic        intrq;
        logic        standby;
        logic        pdEn;
        logic        expired;
        logic        cmdValid;
        logic [2:0]  tries;
        logic [2:0]  sel;
        logic [7:0]  pdCnt;
        logic [7:0]  pdReload;
        logic [7:0]  apm;
        logic [7:0]  feat;
        logic [7:0]  secCnt;
        logic [7:0]  secNum;
        logic [7:0]  cylLo;
        logic [7:0]  cylHi;
        logic [7:0]  drvHd;
        logic [7:0]  cmdCode;
        logic [7:0]  rdData;
        logic [19:0] tickCnt;
    } iwic_st_t;
endpackage

// [hdl/iwic_core.sv]
`timescale 1ns/1ns
// Function
// - normal secure erase time code: 0 unspecified, 1-254 x2 min, 255 long
// - report enhanced secure erase time code with the same encoding
// - low byte of power-management word shows current power level setting
// - security bit 8 is one for maximum level with security enabled, zero for high level or disabled
// - security bit 5 set when enhanced erase is supported
// - expired counter sets bit 4, aborts unlock and erase until reset
// - security bits 3..0 show frozen, locked, enabled, feature supported
// - power word bit 15 marks valid description, bit 14 reads zero
// - power bit 13 flags no level-one commands, bit 12 flags them disabled
// - power word low twelve bits hold maximum current in milliamperes
// - key word bit 0 shows media protection support, bits 1-15 zero
// - timing bits 2-0 give max PIO: 0 older word, 1 mode5, 2 mode6
// - timing bits 5-3 give max multiword DMA: 0 older, 1 mode3, 2 mode4
// - timing bits 8-6 give selected PIO mode with the same code
// - timing bits 11-9 give selected multiword DMA; bits 15-12 zero
// - card-bus bits 2-0 give fastest I/O cycle code 0..3
// - card-bus bits 5-3 give fastest memory cycle code; bits 15-6 zero
// - idle with nonzero count loads timer in 5 ms units, enables power down
// - idle with zero count disables power down, still enters idle
// - idle opcodes: set busy, enter idle, clear busy, raise interrupt
// - multiword DMA selection reads zero while ultra DMA is selected
module iwic_core
    import iwic_pkg::*;
#(
    parameter int TICK_CYC = PD_TICK_MS * CLK_KHZ,
    parameter bit DRIVE_ID = 1'b0
) (
    input  wire logic       core_clk,
    input  wire logic       nrst,
    input  wire iwic_bus_t  bus,
    input  wire iwic_cfg_t  cfg,
    input  wire logic       secFail,
    input  wire logic       cmdDone,
    input  wire logic       cmdFail,
    output logic [7:0]      rdData,
    output logic            intrq,
    output logic            standby,
    output logic            cmdValid,
    output logic [7:0]      cmdCode
);

    //--------------------------------------------------------------
    // helpers
    //--------------------------------------------------------------
    function automatic logic isIdle(input logic [7:0] op);
        isIdle = (op == OP_IDLE_A) || (op == OP_IDLE_B);
    endfunction

    function automatic logic isImm(input logic [7:0] op);
        isImm = (op == OP_IMM_A) || (op == OP_IMM_B);
    endfunction

    function automatic logic isGuarded(input logic [7:0] op);
        isGuarded = (op == OP_SEC_UNLK) || (op == OP_SEC_ERAS);
    endfunction

    // reserved codes are never reported; they fall back to zero
    function automatic logic [2:0] clampMode(input logic [2:0] v,
                                             input logic [2:0] mx);
        clampMode = (v > mx) ? 3'h0 : v;
    endfunction

    localparam logic [19:0] TICK_LAST = 20'(TICK_CYC - 1);

    iwic_st_t          st_q;
    iwic_st_t          st_d;
    logic [7:0][15:0]  idw;
    logic [7:0]        stat;
    logic [7:0]        rdMux;
    logic              tick;
    logic              cmdTake;

    assign tick = (st_q.tickCnt == TICK_LAST);
    // command writes while busy or for the other drive are dropped
    assign cmdTake = bus.wrEn && (bus.addr == TF_CMD) && !st_q.busy &&
                     (st_q.drvHd[DRV_BIT] == DRIVE_ID);

    //--------------------------------------------------------------
    // identify words
    //--------------------------------------------------------------
    always_comb begin
        idw = '0;
        idw[IDX_ERASE][7:0] = cfg.eraseNorm;
        idw[IDX_ENH][7:0]   = cfg.eraseEnh;
        idw[IDX_APM][7:0]   = st_q.apm;
        idw[IDX_SEC][SEC_LVL] = cfg.secEnabled & cfg.secMaxLevel;
        idw[IDX_SEC][SEC_ENH] = cfg.enhEraseSup;
        idw[IDX_SEC][SEC_EXP] = st_q.expired;
        idw[IDX_SEC][SEC_FRZ] = cfg.secFrozen;
        idw[IDX_SEC][SEC_LCK] = cfg.secLocked;
        idw[IDX_SEC][SEC_EN]  = cfg.secEnabled;
        idw[IDX_SEC][SEC_CAP] = cfg.secSupported;
        idw[IDX_PWR][PR_VLD]  = cfg.powerValid;
        idw[IDX_PWR][PR_RSV]  = 1'b0;
        idw[IDX_PWR][PR_NOXP] = cfg.noLevel1Cmds;
        idw[IDX_PWR][PR_XE]   = cfg.level1Disabled;
        idw[IDX_PWR][PR_CUR:0] = cfg.maxCurrent;
        idw[IDX_KEY][KEY_MP]  = cfg.mediaProt;
        idw[IDX_ATA][ATA_PMX +: 3] =
            clampMode(cfg.pioMax, ADV_MAX);
        idw[IDX_ATA][ATA_MMX +: 3] =
            clampMode(cfg.mwMax, ADV_MAX);
        idw[IDX_ATA][ATA_PSL +: 3] =
            clampMode(cfg.pioSel, ADV_MAX);
        // only one DMA mode may appear selected
        if (!cfg.udmaSel) begin
            idw[IDX_ATA][ATA_MSL +: 3] =
                clampMode(cfg.mwSel, ADV_MAX);
        end
        idw[IDX_PCC][PCC_IO +: 3] =
            clampMode(cfg.ioCycMax, CYC_MAX);
        idw[IDX_PCC][PCC_MEM +: 3] =
            clampMode(cfg.memCycMax, CYC_MAX);
    end

    //--------------------------------------------------------------
    // read mux
    //--------------------------------------------------------------
    always_comb begin
        stat = '0;
        stat[ST_BSY] = st_q.busy;
        stat[ST_RDY] = !st_q.busy;
        stat[ST_ERR] = st_q.err;
        rdMux = '0;
        case (bus.addr)
            TF_FEAT: begin
                rdMux[ER_ABRT] = st_q.abrt;
            end
            TF_SECCNT: rdMux = st_q.secCnt;
            TF_SECNUM: rdMux = st_q.secNum;
            TF_CYLLO:  rdMux = st_q.cylLo;
            TF_CYLHI:  rdMux = st_q.cylHi;
            TF_DRVHD:  rdMux = st_q.drvHd;
            TF_CMD:    rdMux = stat;
            ID_SEL:    rdMux = {5'h00, st_q.sel};
            ID_LO:     rdMux = idw[st_q.sel][7:0];
            ID_HI:     rdMux = idw[st_q.sel][15:8];
            APM_REG:   rdMux = st_q.apm;
            default:   rdMux = '0;
        endcase
    end

    //--------------------------------------------------------------
    // next state
    //--------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        st_d.cmdValid = 1'b0;
        st_d.tickCnt = tick ? '0 : st_q.tickCnt + 20'h00001;

        if (bus.rdEn) begin
            st_d.rdData = rdMux;
            // status read acknowledges the interrupt
            if (bus.addr == TF_CMD) begin
                st_d.intrq = 1'b0;
            end
        end

        if (bus.wrEn) begin
            case (bus.addr)
                TF_FEAT:   st_d.feat = bus.wrData;
                TF_SECCNT: st_d.secCnt = bus.wrData;
                TF_SECNUM: st_d.secNum = bus.wrData;
                TF_CYLLO:  st_d.cylLo = bus.wrData;
                TF_CYLHI:  st_d.cylHi = bus.wrData;
                TF_DRVHD:  st_d.drvHd = bus.wrData;
                ID_SEL:    st_d.sel = bus.wrData[2:0];
                APM_REG:   st_d.apm = bus.wrData;
                default: begin
                end
            endcase
        end

        // power-down countdown, frozen while a command runs
        if (tick && st_q.pdEn && !st_q.standby && !st_q.busy) begin
            if (st_q.pdCnt <= 8'h01) begin
                st_d.pdCnt = 8'h00;
                st_d.standby = 1'b1;
            end else begin
                st_d.pdCnt = st_q.pdCnt - 8'h01;
            end
        end

        case (st_q.phase)
            PH_READY: begin
                if (cmdTake) begin
                    st_d.busy = 1'b1;
                    st_d.phase = PH_BUSY;
                    st_d.err = 1'b0;
                    st_d.abrt = 1'b0;
                    st_d.cmdCode = bus.wrData;
                    st_d.tickCnt = '0;
                    st_d.pdCnt = st_q.pdReload;
                    // wake at once so the restarted timer is never stale
                    st_d.standby = 1'b0;
                    if (isIdle(bus.wrData)) begin
                        st_d.act = ACT_IDLE;
                        // zero count turns power down off
                        st_d.pdEn = |st_q.secCnt;
                        st_d.pdReload = st_q.secCnt;
                        st_d.pdCnt = st_q.secCnt;
                    end else if (isImm(bus.wrData)) begin
                        st_d.act = ACT_IMM;
                    end else if (st_q.expired && isGuarded(bus.wrData)) begin
                        st_d.act = ACT_ABORT;
                    end else begin
                        st_d.act = ACT_FWD;
                        st_d.cmdValid = 1'b1;
                    end
                end
            end
            PH_BUSY: begin
                if (st_q.act == ACT_FWD) begin
                    if (cmdDone) begin
                        st_d.busy = 1'b0;
                        st_d.intrq = 1'b1;
                        st_d.err = cmdFail;
                        st_d.abrt = cmdFail;
                        st_d.phase = PH_READY;
                    end
                end else begin
                    // idle, immediate and aborted commands wake the card into idle; forwarded ones never reach here
                    st_d.standby = 1'b0;
                    st_d.phase = PH_ENTER;
                end
            end
            PH_ENTER: begin
                st_d.busy = 1'b0;
                st_d.intrq = 1'b1;
                st_d.phase = PH_READY;
                if (st_q.act == ACT_ABORT) begin
                    st_d.err = 1'b1;
                    st_d.abrt = 1'b1;
                end
            end
            default: st_d.phase = PH_READY;
        endcase

        // hard reset is the only way out of the expired state
        if (secFail && !st_q.expired) begin
            st_d.tries = st_q.tries + 3'h1;
            if (st_q.tries == SEC_TRIES - 3'h1) begin
                st_d.expired = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            st_q <= '0;
            st_q.apm <= APM_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign rdData   = st_q.rdData;
    assign intrq    = st_q.intrq;
    assign standby  = st_q.standby;
    assign cmdValid = st_q.cmdValid;
    assign cmdCode  = st_q.cmdCode;

    //--------------------------------------------------------------
    // assertions
    //--------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);

    property p_idleSeq;
        cmdTake && (isIdle(bus.wrData) || isImm(bus.wrData))
            |=> st_q.busy ##1 st_q.busy ##1 (!st_q.busy && st_q.intrq);
    endproperty
    a_idleSeq: assert property (p_idleSeq)
        else $error("idle busy/interrupt sequence wrong");

    property p_pdLoad;
        cmdTake && isIdle(bus.wrData) && (st_q.secCnt != 8'h00)
            |=> st_q.pdEn && (st_q.pdCnt == $past(st_q.secCnt));
    endproperty
    a_pdLoad: assert property (p_pdLoad)
        else $error("idle count not loaded as timer");

    property p_pdOff;
        cmdTake && isIdle(bus.wrData) && (st_q.secCnt == 8'h00)
            |=> !st_q.pdEn ##2 (st_q.intrq && !st_q.standby);
    endproperty
    a_pdOff: assert property (p_pdOff)
        else $error("zero count did not disable power down");

    property p_abort;
        cmdTake && st_q.expired && isGuarded(bus.wrData)
            |-> ##3 (st_q.err && st_q.abrt && !st_q.busy);
    endproperty
    a_abort: assert property (p_abort)
        else $error("guarded command not aborted after expiry");

    property p_expSticky;
        st_q.expired |=> st_q.expired && idw[IDX_SEC][SEC_EXP];
    endproperty
    a_expSticky: assert property (p_expSticky)
        else $error("expired flag dropped");

    property p_dmaExcl;
        cfg.udmaSel |-> (idw[IDX_ATA][ATA_MSL +: 3] == 3'h0);
    endproperty
    a_dmaExcl: assert property (p_dmaExcl)
        else $error("two DMA modes shown selected");

    property p_pwrRsv;
        !idw[IDX_PWR][PR_RSV] && (idw[IDX_KEY][15:1] == 15'h0000);
    endproperty
    a_pwrRsv: assert property (p_pwrRsv)
        else $error("reserved identify bit set");

    property p_standby;
        tick && st_q.pdEn && !st_q.busy && !st_q.standby &&
            (st_q.pdCnt == 8'h01) && !cmdTake |=> st_q.standby;
    endproperty
    a_standby: assert property (p_standby)
        else $error("timer expiry did not enter standby");

    property p_restart;
        cmdTake |=> (st_q.pdCnt == st_q.pdReload) && !st_q.standby[*2];
    endproperty
    a_restart: assert property (p_restart)
        else $error("command did not restart power-down timer");

    property p_modeClamp;
        (idw[IDX_ATA][ATA_PMX +: 3] <= ADV_MAX) &&
            (idw[IDX_PCC][PCC_IO +: 3] <= CYC_MAX);
    endproperty
    a_modeClamp: assert property (p_modeClamp)
        else $error("reserved timing code reported");

    c_idleTimer: cover property (cmdTake && isIdle(bus.wrData) &&
                                 (st_q.secCnt != 8'h00));
    c_immediate: cover property (cmdTake && isImm(bus.wrData));
    c_standby: cover property (!st_q.standby ##1 st_q.standby);
    c_abort: cover property (st_q.act == ACT_ABORT && st_q.abrt);

endmodule

// [tb/iwic_host.sv]
`timescale 1ns/1ns
// ------------------------------------------------------------
// host side of the task-file port
// ------------------------------------------------------------
// strobes move by nba right after an edge, one transfer per wr or rd task
module iwic_host
    import iwic_pkg::*;
(
    input  wire logic       core_clk,
    output iwic_bus_t       bus,
    input  wire logic [7:0] rdData
);
    initial begin
        bus = '0;
    end

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        bus <= '{addr: a, wrData: d, wrEn: 1'h1, rdEn: 1'h0};
        @(posedge core_clk);
        bus.wrEn <= 1'h0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge core_clk);
        bus <= '{addr: a, wrData: 8'h00, wrEn: 1'h0, rdEn: 1'h1};
        @(posedge core_clk);
        bus.rdEn <= 1'h0;
        #1 d = rdData;
    endtask

    // select and count must land before the opcode is taken
    task automatic issue(input logic [7:0] op, input logic [7:0] n);
        wr(TF_DRVHD, 8'h00);
        wr(TF_SECCNT, n);
        wr(TF_CMD, op);
    endtask
endmodule

// [tb/tb_top.sv]
`timescale 1ns/1ns
module tb_top
    import iwic_pkg::*;
;
    localparam int TICK  = 20;
    localparam int LIMIT = 6000;
    localparam iwic_cfg_t CFG_A = '{eraseNorm: 8'hff, eraseEnh: 8'h01,
        secSupported: 1'h1, enhEraseSup: 1'h1, secEnabled: 1'h1,
        secMaxLevel: 1'h1, secLocked: 1'h0, secFrozen: 1'h1,
        powerValid: 1'h1, noLevel1Cmds: 1'h0, level1Disabled: 1'h1,
        maxCurrent: 12'hfff, mediaProt: 1'h1, pioMax: 3'h2, mwMax: 3'h1,
        pioSel: 3'h1, mwSel: 3'h2, udmaSel: 1'h0, ioCycMax: 3'h3,
        memCycMax: 3'h2};
    localparam iwic_cfg_t CFG_B = '{eraseNorm: 8'h00, eraseEnh: 8'hfe,
        secSupported: 1'h1, enhEraseSup: 1'h0, secEnabled: 1'h1,
        secMaxLevel: 1'h0, secLocked: 1'h1, secFrozen: 1'h0,
        powerValid: 1'h0, noLevel1Cmds: 1'h1, level1Disabled: 1'h0,
        maxCurrent: 12'h0a5, mediaProt: 1'h0, pioMax: 3'h3, mwMax: 3'h7,
        pioSel: 3'h2, mwSel: 3'h1, udmaSel: 1'h1, ioCycMax: 3'h4,
        memCycMax: 3'h3};

    logic       core_clk = 1'h0;
    logic       nrst;
    iwic_bus_t  bus;
    iwic_cfg_t  cfg;
    logic       secFail;
    logic       cmdDone;
    logic       cmdFail;
    logic [7:0] rdData;
    logic       intrq;
    logic       standby;
    logic       cmdValid;
    logic [7:0] cmdCode;
    logic [7:0] apmVal;
    logic       expExp;
    int         errors = 0;
    int         checks = 0;
    int         cyc    = 0;

    always #5 core_clk = ~core_clk;

    iwic_core #(.TICK_CYC(TICK), .DRIVE_ID(1'h0)) iwic_core_inst (
        .core_clk(core_clk), .nrst(nrst), .bus(bus), .cfg(cfg),
        .secFail(secFail), .cmdDone(cmdDone), .cmdFail(cmdFail),
        .rdData(rdData), .intrq(intrq), .standby(standby),
        .cmdValid(cmdValid), .cmdCode(cmdCode));

    iwic_host iwic_host_inst (
        .core_clk(core_clk), .bus(bus), .rdData(rdData));

    // ------------------------------------------------------------
    // checking and closing
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [15:0] exp,
                       input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    always @(posedge core_clk) begin
        cyc++;
        if (cyc == LIMIT) begin
            errors++;
            end_sim();
        end
    end

    // reserved mode codes read back as zero
    function automatic logic [2:0] lim(input logic [2:0] v,
                                       input logic [2:0] m);
        return (v > m) ? 3'h0 : v;
    endfunction

    function automatic logic [15:0] exp_word(input logic [2:0] s);
        case (s)
            IDX_ERASE: return {8'h00, cfg.eraseNorm};
            IDX_ENH:   return {8'h00, cfg.eraseEnh};
            IDX_APM:   return {8'h00, apmVal};
            IDX_SEC:   return {7'h00,
                cfg.secEnabled & cfg.secMaxLevel, 2'h0,
                cfg.enhEraseSup, expExp, cfg.secFrozen,
                cfg.secLocked, cfg.secEnabled, cfg.secSupported};
            IDX_PWR:   return {cfg.powerValid, 1'h0,
                cfg.noLevel1Cmds, cfg.level1Disabled,
                cfg.maxCurrent};
            IDX_KEY:   return {15'h0000, cfg.mediaProt};
            IDX_ATA:   return {4'h0,
                (cfg.udmaSel ? 3'h0 : lim(cfg.mwSel, ADV_MAX)),
                lim(cfg.pioSel, ADV_MAX),
                lim(cfg.mwMax, ADV_MAX),
                lim(cfg.pioMax, ADV_MAX)};
            default:   return {10'h000,
                lim(cfg.memCycMax, CYC_MAX),
                lim(cfg.ioCycMax, CYC_MAX)};
        endcase
    endfunction

    // ------------------------------------------------------------
    // shared sequences
    // ------------------------------------------------------------
    task automatic readw(input logic [2:0] s, output logic [15:0] w);
        logic [7:0] lo;
        logic [7:0] hi;
        iwic_host_inst.wr(ID_SEL, {5'h00, s});
        iwic_host_inst.rd(ID_LO, lo);
        iwic_host_inst.rd(ID_HI, hi);
        w = {hi, lo};
    endtask

    task automatic finish_cmd(input logic [7:0] st);
        logic [7:0] s;
        int         k;
        k = 0;
        while (intrq !== 1'h1 && k < 20) begin
            @(posedge core_clk);
            #1;
            k++;
        end
        chk("intrq", 16'h0001, {15'h0000, intrq});
        iwic_host_inst.rd(TF_CMD, s);
        chk("status", {8'h00, st}, {8'h00, s & 8'hc1});
        chk("intrq clear", 16'h0000, {15'h0000, intrq});
    endtask

    task automatic run_idle(input logic [7:0] op, input logic [7:0] n);
        logic [7:0] s;
        iwic_host_inst.issue(op, n);
        iwic_host_inst.rd(TF_CMD, s);
        chk("busy", 16'h0080, {8'h00, s & 8'hc1});
        finish_cmd(8'h40);
        chk("opcode", {8'h00, op}, {8'h00, cmdCode});
    endtask

    task automatic wait_sb(output int k);
        k = 0;
        while (standby !== 1'h1 && k < 400) begin
            @(posedge core_clk);
            #1;
            k++;
        end
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_words(input string nm);
        logic [15:0] w;
        for (int s = 0; s < 8; s++) begin
            readw(s[2:0], w);
            chk(nm, exp_word(s[2:0]),
                w);
        end
        $display("test %s done", nm);
    endtask

    task automatic t_reset();
        logic [7:0] a;
        chk("rst intrq", 16'h0000, {15'h0000, intrq});
        chk("rst standby", 16'h0000, {15'h0000, standby});
        iwic_host_inst.rd(APM_REG, a);
        chk("apm reset", {8'h00, APM_RST}, {8'h00, a});
        iwic_host_inst.wr(APM_REG, 8'h3c);
        apmVal = 8'h3c;
        iwic_host_inst.rd(4'hd, a);
        chk("unmapped", 16'h0000, {8'h00, a});
        $display("test reset done");
    endtask

    task automatic t_idle();
        logic [7:0] ops [4] = '{OP_IDLE_A, OP_IDLE_B, OP_IMM_A, OP_IMM_B};
        foreach (ops[i]) begin
            run_idle(ops[i], 8'h00);
        end
        repeat (TICK * 6) @(posedge core_clk);
        #1;
        chk("no pd", 16'h0000, {15'h0000, standby});
        $display("test idle done");
    endtask

    task automatic t_power();
        int k;
        run_idle(OP_IDLE_A, 8'h03);
        wait_sb(k);
        chk("pd time", 16'h0001,
            {15'h0000, k >= TICK * 2 && k <= TICK * 3 + 4});
        run_idle(OP_IMM_A, 8'h00);
        chk("wake", 16'h0000, {15'h0000, standby});
        repeat (TICK * 2) @(posedge core_clk);
        run_idle(OP_IMM_B, 8'h00);
        wait_sb(k);
        chk("restart", 16'h0001,
            {15'h0000, k >= TICK * 2 && k <= TICK * 3 + 4});
        run_idle(OP_IDLE_B, 8'h00);
        $display("test power done");
    endtask

    task automatic t_fwd();
        logic [7:0] e;
        int         k;
        iwic_host_inst.issue(8'hec, 8'h00);
        // the pulse is launched on this edge; look once it has settled
        #1;
        k = 0;
        while (cmdValid !== 1'h1 && k < 5) begin
            @(posedge core_clk);
            #1;
            k++;
        end
        chk("forward", {8'h01, 8'hec}, {7'h00, cmdValid, cmdCode});
        @(posedge core_clk);
        cmdDone <= 1'h1;
        cmdFail <= 1'h1;
        @(posedge core_clk);
        cmdDone <= 1'h0;
        cmdFail <= 1'h0;
        #1;
        finish_cmd(8'h41);
        iwic_host_inst.rd(TF_FEAT, e);
        chk("fwd abort", 16'h0004, {8'h00, e & 8'h04});
        $display("test forward done");
    endtask

    task automatic t_sec();
        logic [15:0] w;
        logic [7:0]  e;
        for (int i = 1; i <= 5; i++) begin
            @(posedge core_clk);
            secFail <= 1'h1;
            @(posedge core_clk);
            secFail <= 1'h0;
            expExp = (i == 5);
            readw(IDX_SEC, w);
            chk("expire", exp_word(IDX_SEC), w);
        end
        for (int i = 0; i < 2; i++) begin
            iwic_host_inst.issue(i == 0 ? OP_SEC_UNLK : OP_SEC_ERAS, 8'h00);
            finish_cmd(8'h41);
            iwic_host_inst.rd(TF_FEAT, e);
            chk("sec abort", 16'h0004, {8'h00, e & 8'h04});
        end
        // only a hard reset may clear the expired state
        @(posedge core_clk);
        nrst <= 1'h0;
        @(posedge core_clk);
        nrst <= 1'h1;
        expExp = 1'h0;
        apmVal = APM_RST;
        readw(IDX_SEC, w);
        chk("reset expire", exp_word(IDX_SEC), w);
        $display("test security done");
    endtask

    initial begin
        nrst    = 1'h0;
        cfg     = CFG_A;
        secFail = 1'h0;
        cmdDone = 1'h0;
        cmdFail = 1'h0;
        apmVal  = APM_RST;
        expExp  = 1'h0;
        repeat (6) @(posedge core_clk);
        nrst <= 1'h1;
        @(posedge core_clk);
        #1;
        t_reset();
        t_words("words a");
        t_idle();
        t_power();
        t_fwd();
        t_sec();
        @(posedge core_clk);
        cfg <= CFG_B;
        t_words("words b");
        end_sim();
    end
endmodule
